//--- bench/spllc_control_sva.sv
// Purpose: Port-level checks of the synthesizer control block
// Assumes: Pin edges act three clocks after they change
// Notes: Mirrors the serial port; settle counters absorb pin latency
`default_nettype none

module spllc_control_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Pins watched
    input wire logic serial_clk_i, latch_strobe_i, serial_data_i, ref_osc_in_i, ref_osc_out_o,
    input wire logic low_band_input_i, mid_band_input_i, high_band_input_i,
    input wire logic phase_detect_out_o, phase_detect_oe_o, first_output_pin_o, second_output_pin_o
);
    logic [2:0] c_q, l_q, d_q;
    logic [3:0] rf_q, lq_q, sq_q, aq_q;
    logic [19:0] sr_q, setup_q;
    logic t2_q;
    logic [2:0] pr_q;
    wire [3:0] rf_now = {high_band_input_i, mid_band_input_i, low_band_input_i, ref_osc_in_i};
    wire l_up = l_q[1] & ~l_q[2] & pr_q[2];
    wire shift_ev = c_q[1] & ~c_q[2] & ~l_q[1] & pr_q[2];
    wire load_ev = l_up & c_q[1];
    wire step_ev = l_up & ~c_q[1];
    wire t1 = setup_q[18];
    wire [1:0] ab = setup_q[17:16];

    // Serial port mirror; counters saturate so long idle stays settled
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            {c_q, l_q, d_q, rf_q} <= 13'h0000;
            {sr_q, setup_q, t2_q} <= 41'h0;
            {lq_q, sq_q, aq_q} <= 12'h000;
            pr_q <= 3'h0;
        end else begin
            pr_q <= {pr_q[1:0], 1'b1};
            c_q <= {c_q[1:0], serial_clk_i};
            l_q <= {l_q[1:0], latch_strobe_i};
            d_q <= {d_q[1:0], serial_data_i};
            rf_q <= rf_now;
            if (shift_ev) sr_q <= {d_q[1], sr_q[19:1]};
            if (load_ev && !sr_q[19]) setup_q <= sr_q;
            if (load_ev && sr_q[19]) t2_q <= sr_q[18];
            lq_q <= (load_ev | step_ev) ? 4'h0 : lq_q + {3'h0, lq_q != 4'hf};
            sq_q <= (load_ev | step_ev | shift_ev) ? 4'h0 : sq_q + {3'h0, sq_q != 4'hf};
            aq_q <= (rf_now != rf_q) ? 4'h0 : aq_q + {3'h0, aq_q != 4'hf};
        end
    end

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_pins_direct: assert property (lq_q > 4'h7 && !t1 |->
        first_output_pin_o == ab[0] && second_output_pin_o == ab[1]) else $error("pins differ from output bits");
    chk_load_latency: assert property (load_ev && !sr_q[19] && !sr_q[18] |->
        ##[2:6] first_output_pin_o == setup_q[16] && second_output_pin_o == setup_q[17])
        else $error("setup word late on pins");
    chk_main_keeps_ab: assert property (load_ev && sr_q[19] && !t1 |=>
        ($stable(first_output_pin_o) && $stable(second_output_pin_o))[*8]) else $error("main word moved pins");
    chk_unlock_pin: assert property (lq_q > 4'h7 && t1 && (!t2_q || ab == 2'h1) |->
        first_output_pin_o == phase_detect_oe_o || first_output_pin_o == $past(phase_detect_oe_o))
        else $error("unlock pin differs from detector");
    chk_readback_bit: assert property (sq_q > 4'h7 && lq_q > 4'h7 && t1 && !t2_q |->
        second_output_pin_o == sr_q[0]) else $error("readback bit wrong");
    chk_test_b_high: assert property (lq_q > 4'h7 && t1 && t2_q && ab[1] |->
        !second_output_pin_o) else $error("second pin not low in test mode");
    chk_test_quiet: assert property (lq_q > 4'h7 && t1 && t2_q && ab == 2'h0 && aq_q > 4'h7 |->
        $stable(first_output_pin_o) && $stable(second_output_pin_o)) else $error("divider pin moved idle");
    chk_detector_idle: assert property (aq_q > 4'h7 |->
        $stable(phase_detect_oe_o) && $stable(phase_detect_out_o)) else $error("detector moved idle");

    cover property (load_ev && sr_q[19]);
    cover property (step_ev);
    cover property ($rose(phase_detect_oe_o));
endmodule // spllc_control_sva

bind spllc_control spllc_control_sva u_spllc_control_sva (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .serial_clk_i(serial_clk_i), .latch_strobe_i(latch_strobe_i), .serial_data_i(serial_data_i),
    .ref_osc_in_i(ref_osc_in_i), .ref_osc_out_o(ref_osc_out_o), .low_band_input_i(low_band_input_i),
    .mid_band_input_i(mid_band_input_i), .high_band_input_i(high_band_input_i),
    .phase_detect_out_o(phase_detect_out_o), .phase_detect_oe_o(phase_detect_oe_o),
    .first_output_pin_o(first_output_pin_o), .second_output_pin_o(second_output_pin_o));

`default_nettype wire

//--- bench/spllc_control_tb.sv
// Purpose: Self-checking bench for the synthesizer control block
// Assumes: Pulses four clocks high, four low, slow enough to be counted
// Notes: Divider ratios are seen as toggle counts on the pins
`default_nettype none

`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); fails++; end end

module spllc_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic serial_clk, latch_strobe, serial_data;
    logic ref_osc = 1'b0;
    logic [2:0] rf = 3'h0;
    logic pin_a, pin_b, pd_out, pd_oe, prev_a, prev_b, osc_out;
    logic [19:0] rb;
    int fails = 0;
    int tests_run = 0;
    int tog_a = 0;
    int tog_b = 0;
    int ta, tb;
    // Band rows: select code, pulse count, reference toggles
    logic [1:0] row_sel [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
    int row_n [4] = '{12, 12, 24, 48};
    int row_ref [4] = '{2, 2, 4, 8};

    always #5 sys_clk_i = ~sys_clk_i;

    spllc_control u_spllc_control (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .serial_clk_i(serial_clk),
        .latch_strobe_i(latch_strobe), .serial_data_i(serial_data), .ref_osc_in_i(ref_osc), .ref_osc_out_o(osc_out),
        .low_band_input_i(rf[0]), .mid_band_input_i(rf[1]), .high_band_input_i(rf[2]),
        .phase_detect_out_o(pd_out), .phase_detect_oe_o(pd_oe), .first_output_pin_o(pin_a),
        .second_output_pin_o(pin_b));
    spllc_host u_spllc_host (.sys_clk_i(sys_clk_i), .readback_i(pin_b), .serial_clk_o(serial_clk),
        .latch_strobe_o(latch_strobe), .serial_data_o(serial_data));

    // Toggle counters; tests read differences, so the first count is harmless
    always @(posedge sys_clk_i) begin
        prev_a <= pin_a;
        prev_b <= pin_b;
        if (pin_a !== prev_a) tog_a++;
        if (pin_b !== prev_b) tog_b++;
    end

    function automatic logic [19:0] setup(input logic [13:0] r, input logic [1:0] sel, input logic [1:0] ab,
        input logic t1);
        return {1'b0, t1, ab, sel, r};
    endfunction

    // Pulse masked inputs {high, mid, low, ref}, then let counts land
    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n) begin
            {rf, ref_osc} <= m;
            repeat (4) @(posedge sys_clk_i);
            {rf, ref_osc} <= 4'h0;
            repeat (4) @(posedge sys_clk_i);
        end
        repeat (8) @(posedge sys_clk_i);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog, several times the expected run
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        fails++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        `CHK("reset pins", 5'h00, {pin_a, pin_b, pd_oe, pd_out, osc_out})
        // Band rows first need the pins, so direct drive comes first
        for (int i = 0; i < 4; i++) begin
            u_spllc_host.send(setup(14'h0004, 2'h0, i[1:0], 1'b0), 1'b1);
            `CHK("direct pins", i[1:0], {pin_b, pin_a})
        end
        u_spllc_host.send(setup(14'h0000, 2'h0, 2'h0, 1'b0), 1'b0);
        u_spllc_host.send({2'h2, 18'h00004}, 1'b1);
        `CHK("held pins", 2'h3, {pin_b, pin_a})
        $display("test direct done");
        u_spllc_host.send(setup(14'h0004, 2'h1, 2'h1, 1'b1), 1'b1);
        u_spllc_host.read(rb);
        `CHK("readback", 20'h54004, rb)
        $display("test readback done");
        // Reference tick alone, then main tick, then main alone
        pulse(4'h1, 6);
        `CHK("lagging", 3'h5, {pd_oe, pd_out, pin_a})
        `CHK("osc feedback", 1'b1, osc_out)
        pulse(4'h2, 6);
        `CHK("in phase", 3'h0, {pd_oe, pd_out, pin_a})
        pulse(4'h2, 6);
        `CHK("leading", 3'h7, {pd_oe, pd_out, pin_a})
        $display("test detector done");
        for (int i = 0; i < 4; i++) begin
            u_spllc_host.send(setup(14'h0004, row_sel[i], 2'h0, 1'b1), 1'b1);
            u_spllc_host.send({2'h3, 18'h00004}, 1'b1);
            ta = tog_a;
            tb = tog_b;
            pulse(4'hf, row_n[i]);
            `CHK("ref div toggles", row_ref[i], tog_a - ta)
            `CHK("main div toggles", 2, tog_b - tb)
        end
        $display("test bands done");
        // Low band, count stepped 4 to 6, then back to 5
        u_spllc_host.send(setup(14'h0004, 2'h0, 2'h0, 1'b1), 1'b1);
        u_spllc_host.send({2'h3, 18'h00004}, 1'b1);
        u_spllc_host.step(1'b1);
        u_spllc_host.step(1'b1);
        tb = tog_b;
        pulse(4'he, 16);
        `CHK("step up toggles", 2, tog_b - tb)
        u_spllc_host.step(1'b0);
        tb = tog_b;
        pulse(4'he, 14);
        `CHK("step down toggles", 2, tog_b - tb)
        $display("test step done");
        // Second output bit high in test mode: main divider on the first pin
        u_spllc_host.send(setup(14'h0004, 2'h0, 2'h2, 1'b1), 1'b1);
        ta = tog_a;
        pulse(4'he, 14);
        `CHK("main on first pin", 2, tog_a - ta)
        `CHK("second pin low", 1'b0, pin_b)
        $display("test divider view done");
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        @(posedge sys_clk_i);
        `CHK("mid reset pins", 5'h00, {pin_a, pin_b, pd_oe, pd_out, osc_out})
        $display("test reset done");
        complete_run();
    end
endmodule // spllc_control_tb

`default_nettype wire

//--- bench/spllc_host.sv
// Purpose: Host model driving the three-wire serial control pins
// Assumes: Every pin level holds at least five system clocks
// Notes: Lines stay driven; clock rests high after a word, low after a step
`default_nettype none

module spllc_host (
    // Clock and readback pin
    input wire logic sys_clk_i,
    input wire logic readback_i,
    // Serial control pins
    output logic serial_clk_o,
    output logic latch_strobe_o,
    output logic serial_data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = 5;

    // Idle levels, clock high so the first word starts with a fall
    initial begin
        serial_clk_o = 1'b1;
        latch_strobe_o = 1'b0;
        serial_data_o = 1'b0;
    end

    // Whole clocks only, so the synchroniser never misses a level
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // Twenty bits first bit first, then a strobe with the clock high
    task automatic send(input logic [19:0] w, input logic do_latch);
        for (int i = 0; i < 20; i++) begin
            serial_clk_o <= 1'b0;
            serial_data_o <= w[i];
            hold(HOLD);
            serial_clk_o <= 1'b1;
            hold(HOLD);
        end
        latch_strobe_o <= do_latch;
        hold(HOLD);
        latch_strobe_o <= 1'b0;
        hold(HOLD);
    endtask

    // Clock low, direction on data, one strobe pulse
    task automatic step(input logic up);
        serial_clk_o <= 1'b0;
        serial_data_o <= up;
        hold(HOLD);
        latch_strobe_o <= 1'b1;
        hold(HOLD);
        latch_strobe_o <= 1'b0;
        hold(HOLD);
    endtask

    // Sample the readback pin, then clock the next bit out
    task automatic read(output logic [19:0] r);
        for (int i = 0; i < 20; i++) begin
            r[i] = readback_i;
            serial_clk_o <= 1'b0;
            hold(HOLD);
            serial_clk_o <= 1'b1;
            hold(HOLD + 2);
        end
    endtask
endmodule // spllc_host

`default_nettype wire

//--- logic/spllc_control.sv
// Purpose: Digital control of a synthesizer PLL behind a three-wire serial port
// Assumes: Pin inputs toggle well below half the system clock rate
// Notes: RF and reference inputs are sampled, so the model is a
//        functional stand-in for the high-speed counting chain
`default_nettype none

// How it works
// R1: Shift data on clock rise, strobe low
// R2: Strobe rise with clock high latches word
// R3: Host holds lines steady while strobe high
// R4: Last bit picks destination register
// R5: Setup word first, then main word
// R6: Host resends setup on band change
// R7: Counts arrive binary, least significant first
// R8: Setup word field order fixed
// R9: Reference factor is count plus two
// R10: Two select bits choose RF input
// R11: Function low drives pins from bits
// R12: Function high gives unlock and readback
// R13: Test bits route divider outputs out
// R14: Main word: count, test bit, destination
// R15: Main factor depends on selected band
// R16: Mid and high ranges from counts
// R17: Strobe pulse with clock low steps count
// R18: Readback shifts out on second pin
// R19: Detector drives high, low or floats
// R20: Step mode acts on strobe rise
// R21: New values apply only at latch
// R22: Unlock whenever detector actively drives
module spllc_control (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Serial control pins
    input wire logic serial_clk_i,
    input wire logic latch_strobe_i,
    input wire logic serial_data_i,
    // Reference oscillator
    input wire logic ref_osc_in_i,
    output logic ref_osc_out_o,
    // RF inputs
    input wire logic low_band_input_i,
    input wire logic mid_band_input_i,
    input wire logic high_band_input_i,
    // Phase detector, three-state
    output logic phase_detect_out_o,
    output logic phase_detect_oe_o,
    // Multipurpose outputs
    output logic first_output_pin_o,
    output logic second_output_pin_o
);
    // Synchroniser and edge history
    logic [spllc_pkg::PIN_N-1:0] pin_meta_q;
    logic [spllc_pkg::PIN_N-1:0] pin_sync_q;
    logic [spllc_pkg::PIN_N-1:0] pin_prev_q;
    logic [spllc_pkg::PIN_N-1:0] pin_rise;
    logic [2:0] prime_q;

    // Serial port state
    logic [spllc_pkg::SHIFT_W-1:0] shift_q;
    logic shift_en;
    logic latch_rise;
    logic load_en;
    logic step_en;

    // Latched setup fields
    logic [spllc_pkg::REF_W-1:0] ref_count_q;
    logic sel_first_q;
    logic sel_second_q;
    logic out_a_q;
    logic out_b_q;
    logic func_q;

    // Latched main divider fields
    logic [spllc_pkg::MAIN_W-1:0] main_count_q;
    logic test2_q;

    // Counting chain
    spllc_pkg::spllc_band_t band;
    logic prescale_q;
    logic ref_div_out_q;
    logic main_div_out_q;
    logic up_q;
    logic dn_q;
    logic unlock;
    logic first_pin_q;
    logic second_pin_q;
    logic ref_osc_out_q;

    spllc_div_if #(.W(spllc_pkg::REF_MOD_W)) ref_div ();
    spllc_div_if #(.W(spllc_pkg::MAIN_MOD_W)) main_div ();

    // Rising edge of a sampled level
    function automatic logic rise_of(input logic cur, input logic prev);
        rise_of = cur & ~prev;
    endfunction

    // Band decode from the two select bits
    function automatic spllc_pkg::spllc_band_t band_of(input logic first, input logic second);
        if (!second) begin
            band_of = spllc_pkg::BAND_LOW;
        end else if (!first) begin
            band_of = spllc_pkg::BAND_MID;
        end else begin
            band_of = spllc_pkg::BAND_HIGH;
        end
    endfunction

    // True main division factor seen after the prescaler
    function automatic logic [spllc_pkg::MAIN_MOD_W-1:0] main_modulus(
        input spllc_pkg::spllc_band_t b,
        input logic [spllc_pkg::MAIN_W-1:0] n
    );
        case (b)
            spllc_pkg::BAND_LOW: begin
                main_modulus = spllc_pkg::MAIN_MOD_W'(n) + spllc_pkg::MAIN_OFFSET_LOW;
            end
            default: begin
                main_modulus = spllc_pkg::MAIN_MOD_W'(n) + spllc_pkg::MAIN_OFFSET_UPPER;
            end
        endcase
    endfunction

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= {high_band_input_i, mid_band_input_i, low_band_input_i,
                           ref_osc_in_i, serial_data_i, latch_strobe_i, serial_clk_i};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Previous synchronised level, for edges
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_prev_q <= '0;
        end else begin
            pin_prev_q <= pin_sync_q;
        end
    end

    // History is primed for three clocks, so a pin high through reset makes no false edge
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prime_q <= '0;
        end else begin
            prime_q <= {prime_q[1:0], 1'b1};
        end
    end

    // Edge detect per pin
    always_comb begin
        for (int i = 0; i < spllc_pkg::PIN_N; i++) begin
            pin_rise[i] = rise_of(pin_sync_q[i], pin_prev_q[i]) & prime_q[2];
        end
    end

    // Serial port events
    assign shift_en = pin_rise[spllc_pkg::PIN_SCLK] & ~pin_sync_q[spllc_pkg::PIN_LATCH]; // [R1]
    assign latch_rise = pin_rise[spllc_pkg::PIN_LATCH]; // [R20]
    // Clock level at the strobe edge picks latch or step; host keeps it steady [R3]
    assign load_en = latch_rise & pin_sync_q[spllc_pkg::PIN_SCLK]; // [R2]
    assign step_en = latch_rise & ~pin_sync_q[spllc_pkg::PIN_SCLK]; // [R17]

    // Shift register, first bit ends at bit 0 after twenty shifts
    // Contents are kept through a latch so they can be read back
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            shift_q <= spllc_pkg::SHIFT_RST;
        end else if (shift_en) begin
            shift_q <= {pin_sync_q[spllc_pkg::PIN_DATA], shift_q[spllc_pkg::SHIFT_W-1:1]}; // [R1] [R7] [R18]
        end
    end

    // Setup word, taken only when the last bit is low
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_count_q <= spllc_pkg::REF_COUNT_RST;
            sel_first_q <= spllc_pkg::FLAG_RST;
            sel_second_q <= spllc_pkg::FLAG_RST;
            out_a_q <= spllc_pkg::FLAG_RST;
            out_b_q <= spllc_pkg::FLAG_RST;
            func_q <= spllc_pkg::FLAG_RST;
        end else if (load_en && !shift_q[spllc_pkg::DEST_BIT]) begin // [R4] [R21] [R5]
            ref_count_q <= shift_q[spllc_pkg::REF_LSB +: spllc_pkg::REF_W]; // [R8] [R7]
            sel_first_q <= shift_q[spllc_pkg::SEL_FIRST_BIT]; // [R8]
            sel_second_q <= shift_q[spllc_pkg::SEL_SECOND_BIT];
            out_a_q <= shift_q[spllc_pkg::OUT_A_BIT];
            out_b_q <= shift_q[spllc_pkg::OUT_B_BIT];
            func_q <= shift_q[spllc_pkg::FUNC_BIT];
        end
    end

    // Main count: loaded by a high destination word, or stepped by one
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            main_count_q <= spllc_pkg::MAIN_COUNT_RST;
        end else if (load_en && shift_q[spllc_pkg::DEST_BIT]) begin // [R4] [R21]
            main_count_q <= shift_q[spllc_pkg::MAIN_LSB +: spllc_pkg::MAIN_W]; // [R14] [R7]
        end else if (step_en) begin
            // Data high counts up, low counts down; wraps at the ends [R17]
            if (pin_sync_q[spllc_pkg::PIN_DATA]) begin
                main_count_q <= spllc_pkg::MAIN_W'(main_count_q + spllc_pkg::MAIN_W'(1));
            end else begin
                main_count_q <= spllc_pkg::MAIN_W'(main_count_q - spllc_pkg::MAIN_W'(1));
            end
        end
    end

    // Second test bit rides in the main word
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            test2_q <= spllc_pkg::FLAG_RST;
        end else if (load_en && shift_q[spllc_pkg::DEST_BIT]) begin
            test2_q <= shift_q[spllc_pkg::TEST2_BIT]; // [R14]
        end
    end

    // Input selection
    assign band = band_of(sel_first_q, sel_second_q); // [R10] [R6]

    // Divide-by-two prescaler in front of the high-band path
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            prescale_q <= 1'b0;
        end else if (pin_rise[spllc_pkg::PIN_HIGH]) begin
            prescale_q <= ~prescale_q; // [R15]
        end
    end

    // Reference divider: count plus two oscillator edges per tick
    assign ref_div.modulus = spllc_pkg::REF_MOD_W'(ref_count_q) + spllc_pkg::REF_OFFSET; // [R9]
    assign ref_div.step = pin_rise[spllc_pkg::PIN_REF];

    // Main divider fed from the selected input
    // High band counts every second edge, doubling the factor [R15] [R16]
    assign main_div.modulus = main_modulus(band, main_count_q); // [R15]
    always_comb begin
        case (band)
            spllc_pkg::BAND_LOW: begin
                main_div.step = pin_rise[spllc_pkg::PIN_LOW];
            end
            spllc_pkg::BAND_MID: begin
                main_div.step = pin_rise[spllc_pkg::PIN_MID];
            end
            spllc_pkg::BAND_HIGH: begin
                main_div.step = pin_rise[spllc_pkg::PIN_HIGH] & prescale_q;
            end
            default: begin
                main_div.step = 1'b0;
            end
        endcase
    end

    spllc_divider #(.W(spllc_pkg::REF_MOD_W)) u_ref_div (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .bus(ref_div.divider)
    );

    spllc_divider #(.W(spllc_pkg::MAIN_MOD_W)) u_main_div (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .bus(main_div.divider)
    );

    // Square-ish divider outputs for the test view
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_div_out_q <= 1'b0;
            main_div_out_q <= 1'b0;
        end else begin
            ref_div_out_q <= ref_div_out_q ^ ref_div.tick;
            main_div_out_q <= main_div_out_q ^ main_div.tick;
        end
    end

    // Phase/frequency detector: first tick sets its flag, the other clears both
    // Coincident ticks cancel, which reads as in phase
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else if ((up_q | main_div.tick) & (dn_q | ref_div.tick)) begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end else begin
            up_q <= up_q | main_div.tick;
            dn_q <= dn_q | ref_div.tick;
        end
    end

    // Leading divided input drives high, lagging drives low, else float
    assign phase_detect_out_o = up_q; // [R19]
    assign phase_detect_oe_o = up_q | dn_q; // [R19]
    assign unlock = up_q | dn_q; // [R22]

    // Multipurpose pin routing
    // Combinations left open by the function table fall back to the plain view
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            first_pin_q <= 1'b0;
            second_pin_q <= 1'b0;
        end else if (!func_q) begin
            first_pin_q <= out_a_q; // [R11]
            second_pin_q <= out_b_q; // [R11]
        end else if (test2_q && out_b_q) begin
            first_pin_q <= main_div_out_q; // [R13]
            second_pin_q <= 1'b0;
        end else if (test2_q && !out_a_q) begin
            first_pin_q <= ref_div_out_q; // [R13]
            second_pin_q <= main_div_out_q; // [R13]
        end else begin
            first_pin_q <= unlock; // [R12]
            second_pin_q <= shift_q[0]; // [R12] [R18]
        end
    end

    // Oscillator feedback is the inverted sampled input
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ref_osc_out_q <= 1'b0;
        end else begin
            ref_osc_out_q <= ~pin_sync_q[spllc_pkg::PIN_REF];
        end
    end

    assign first_output_pin_o = first_pin_q;
    assign second_output_pin_o = second_pin_q;
    assign ref_osc_out_o = ref_osc_out_q;
endmodule : spllc_control

`default_nettype wire

//--- logic/spllc_div_if.sv
// Purpose: Carrier between the control logic and a counting divider
// Assumes: Step is a one-cycle pulse in the system clock domain
// Notes: Width follows the divider it feeds
`default_nettype none

interface spllc_div_if #(parameter int W = 19);
    logic step;
    logic [W-1:0] modulus;
    logic tick;
    modport divider (input step, input modulus, output tick);
    modport user (output step, output modulus, input tick);
endinterface : spllc_div_if

`default_nettype wire

//--- logic/spllc_divider.sv
// Purpose: Counts step pulses and ticks once every modulus steps
// Assumes: Modulus of at least one; zero wraps the compare to all ones and divides by 2**W
// Notes: A new modulus applies from the next step onward
`default_nettype none

module spllc_divider #(
    parameter int W = 19
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Control side
    spllc_div_if.divider bus
);
    logic [W-1:0] count_q;
    logic tick_q;
    logic at_end;

    // Terminal compare uses >= so a lowered modulus never runs away
    assign at_end = (count_q >= W'(bus.modulus - W'(1)));

    // Step counter
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            count_q <= '0;
        end else if (bus.step) begin
            count_q <= at_end ? '0 : W'(count_q + W'(1));
        end
    end

    // Registered terminal tick, one cycle wide
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= bus.step & at_end;
        end
    end

    assign bus.tick = tick_q;
endmodule : spllc_divider

`default_nettype wire

//--- logic/spllc_pkg.sv
// Purpose: Shared constants and types for the synthesizer control block
// Assumes: One system clock; all pins are asynchronous to it
// Notes: Word fields are bit positions after 20 shifts, first bit at 0
`default_nettype none

package spllc_pkg;
    // Word and field widths
    localparam int SHIFT_W = 20;
    localparam int REF_W = 14;
    localparam int MAIN_W = 18;
    localparam int REF_MOD_W = 15;
    localparam int MAIN_MOD_W = 19;

    // Field positions in the shift register
    localparam int DEST_BIT = 19;
    localparam int REF_LSB = 0;
    localparam int SEL_FIRST_BIT = 14;
    localparam int SEL_SECOND_BIT = 15;
    localparam int OUT_A_BIT = 16;
    localparam int OUT_B_BIT = 17;
    localparam int FUNC_BIT = 18;
    localparam int MAIN_LSB = 0;
    localparam int TEST2_BIT = 18;

    // Reset values
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 20'h00000;
    localparam logic [REF_W-1:0] REF_COUNT_RST = 14'h0000;
    localparam logic [MAIN_W-1:0] MAIN_COUNT_RST = 18'h00000;
    localparam logic FLAG_RST = 1'b0;

    // Offsets between stored counts and true division factors
    localparam logic [REF_MOD_W-1:0] REF_OFFSET = 15'h0002;
    localparam logic [MAIN_MOD_W-1:0] MAIN_OFFSET_LOW = 19'h00002;
    localparam logic [MAIN_MOD_W-1:0] MAIN_OFFSET_UPPER = 19'h00008;

    // Index of each pin in the synchroniser vector
    localparam int PIN_SCLK = 0;
    localparam int PIN_LATCH = 1;
    localparam int PIN_DATA = 2;
    localparam int PIN_REF = 3;
    localparam int PIN_LOW = 4;
    localparam int PIN_MID = 5;
    localparam int PIN_HIGH = 6;
    localparam int PIN_N = 7;

    // Selected RF input
    typedef enum logic [1:0] {
        BAND_LOW,
        BAND_MID,
        BAND_HIGH
    } spllc_band_t;
endpackage : spllc_pkg

`default_nettype wire
